// *** hdl/hwm_pkg.sv ***
// Shared constants and types for the hardware-monitor register block
`default_nettype none
package hwm_pkg;
    // Register indices
    localparam logic [7:0] IDX_VOLT_BASE = 8'h20;
    localparam logic [7:0] IDX_ASUP      = 8'h22;
    localparam logic [7:0] IDX_MSUP      = 8'h23;
    localparam logic [7:0] IDX_VOLT_LAST = 8'h25;
    localparam logic [7:0] IDX_SYS_TEMP  = 8'h27;
    localparam logic [7:0] IDX_I2C_ADDR  = 8'h48;
    localparam logic [7:0] IDX_BANK      = 8'h4E;
    localparam logic [7:0] IDX_PAIR_HI   = 8'h50;
    localparam logic [7:0] IDX_PAIR_LO   = 8'h51;
    localparam logic [7:0] IDX_SEL_A     = 8'h59;
    localparam logic [7:0] IDX_SEL_B     = 8'h5D;
    localparam logic [7:0] IDX_SEL_C     = 8'h5E;
    localparam logic [7:0] CFG_SST_ADDR  = 8'hF1;
    localparam logic [2:0] BANK_0        = 3'h0;
    localparam logic [2:0] BANK_1        = 3'h1;
    localparam logic [2:0] BANK_5        = 3'h5;
    // Values after reset
    localparam logic [7:0] RST_I2C_ADDR  = 8'h2D;
    localparam logic [7:0] RST_SST_ADDR  = 8'h48;
    localparam logic [7:0] RST_SEL       = 8'h00;
    localparam logic [2:0] RST_BANK      = 3'h0;
    // Converter sequence slots
    localparam logic [3:0] SLOT_STBY     = 4'h6;
    localparam logic [3:0] SLOT_BATT     = 4'h7;
    localparam logic [3:0] SLOT_SYS      = 4'h8;
    localparam logic [3:0] SLOT_CPU      = 4'h9;
    // Converter scale
    localparam int LSB_MV        = 8;
    localparam int CODE_STEPS    = 256;
    localparam int FULL_SCALE_MV = LSB_MV * CODE_STEPS;
    // Single-wire idle time before a message start
    localparam int CLK_NS        = 100;
    localparam int SST_IDLE_NS   = 5000;
    localparam logic [15:0] SST_IDLE_CYC = 16'(SST_IDLE_NS / CLK_NS);

    typedef enum logic [1:0] {TM_THERMISTOR, TM_DIODE_V, TM_DIODE_I} hwm_tmode_t;

    typedef struct packed {
        logic       cs;
        logic       port;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } hwm_io_req_t;

    typedef struct packed {
        logic       valid;
        logic [8:0] code;
    } hwm_adc_t;
endpackage
`default_nettype wire

// *** hdl/hwm_readout.sv ***
// Hardware-monitor register file with index/data and serial access, plus single-wire bit-rate capture
// Summary of operation
// - Serial slave port reads and writes the same registers as the index/data path.
// - Serial slave answers at the address held in serial_slave_address.
// - Voltage codes are 8-bit unsigned (low bits of the 9-bit converter code), 256 steps of 8 mV.
// - Eight voltage channels are sequenced through one converter.
// - Voltage results read in bank 0 at indices 20h to 25h.
// - Main 5 V reading at 23h, analog supply reading at 22h.
// - Standby reading at bank 5 index 50h, battery at bank 5 index 51h.
// - System temperature 8-bit, processor temperature 9-bit two's complement.
// - System_temp_reading returns the system temperature.
// - Processor temperature upper bits at bank 1 50h, low bit in 51h bit 7.
// - Per-channel sensor mode chosen by bank 0 indices 59h, 5Dh, 5Eh.
// - Single-wire port is a slave that only captures its bit rate; no converter data reaches it.
// - Single-wire address sits in config F1h, 48h after reset.
// - Single-wire bit rate is measured afresh at each message start.
// - Index 4Eh selects the active register bank.
// - Host writes an index to one port, then accesses data at the next.
`default_nettype none
module hwm_readout (
    input  wire logic                clock,         // 10 MHz system clock
    input  wire logic                nrst,          // Asynchronous reset, active low
    input  wire hwm_pkg::hwm_io_req_t io_req,       // Index/data port request
    output logic [7:0]               io_rdata,      // Index/data read data
    input  wire logic                cfg_wr,        // Config space write strobe
    input  wire logic [7:0]          cfg_index,     // Config space index
    input  wire logic [7:0]          cfg_wdata,     // Config space write data
    output logic [7:0]               cfg_rdata,     // Config space read data
    input  wire logic                scl_i,         // Serial clock pin
    input  wire logic                sda_i,         // Serial data pin level
    output logic                     sda_o,         // Serial data drive value
    output logic                     sda_oe,        // Serial data drive enable
    input  wire hwm_pkg::hwm_adc_t   adc,           // Converter result
    output logic [3:0]               adc_slot,      // Converter channel select
    output hwm_pkg::hwm_tmode_t      sys_mode,      // System sensor mode
    output hwm_pkg::hwm_tmode_t      cpu_mode,      // Processor sensor mode
    input  wire logic                sst_i,         // Single-wire pin level
    output logic [7:0]               sst_address,   // Single-wire slave address
    output logic [15:0]              sst_bit_time   // Measured bit time, cycles
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_q_ff;
    logic       rst_n;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_q_ff <= 2'h0;
        end else begin
            rst_q_ff <= {rst_q_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_q_ff[1];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic [2:0] scl_q_ff, sda_q_ff, sst_q_ff;
    logic       scl_lvl_ff, sda_lvl_ff, sst_lvl_ff;
    logic       nxt_scl_lvl, nxt_sda_lvl, nxt_sst_lvl;
    logic       scl_rise, scl_fall, i2c_start, i2c_stop, sst_rise;
    always_comb begin
        nxt_scl_lvl = (scl_q_ff[1] == scl_q_ff[2]) ? scl_q_ff[2] : scl_lvl_ff;
        nxt_sda_lvl = (sda_q_ff[1] == sda_q_ff[2]) ? sda_q_ff[2] : sda_lvl_ff;
        nxt_sst_lvl = (sst_q_ff[1] == sst_q_ff[2]) ? sst_q_ff[2] : sst_lvl_ff;
        scl_rise    = nxt_scl_lvl & ~scl_lvl_ff;
        scl_fall    = ~nxt_scl_lvl & scl_lvl_ff;
        i2c_start   = scl_lvl_ff & nxt_scl_lvl & sda_lvl_ff & ~nxt_sda_lvl;
        i2c_stop    = scl_lvl_ff & nxt_scl_lvl & ~sda_lvl_ff & nxt_sda_lvl;
        sst_rise    = nxt_sst_lvl & ~sst_lvl_ff;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_ff   <= 3'h7;
            sda_q_ff   <= 3'h7;
            sst_q_ff   <= 3'h0;
            scl_lvl_ff <= 1'b1;
            sda_lvl_ff <= 1'b1;
            sst_lvl_ff <= 1'b0;
        end else begin
            scl_q_ff   <= {scl_q_ff[1:0], scl_i};
            sda_q_ff   <= {sda_q_ff[1:0], sda_i};
            sst_q_ff   <= {sst_q_ff[1:0], sst_i};
            scl_lvl_ff <= nxt_scl_lvl;
            sda_lvl_ff <= nxt_sda_lvl;
            sst_lvl_ff <= nxt_sst_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file, index/data port and converter sequencer
    logic [7:0]  volt_ff [8];
    logic [7:0]  nxt_volt [8];
    logic [7:0]  sys_temp_ff, nxt_sys_temp;
    logic [8:0]  cpu_temp_ff, nxt_cpu_temp;
    logic [7:0]  i2c_addr_ff, nxt_i2c_addr, sst_addr_ff, nxt_sst_addr;
    logic [7:0]  sel_a_ff, sel_b_ff, sel_c_ff, nxt_sel_a, nxt_sel_b, nxt_sel_c;
    logic [2:0]  bank_ff, nxt_bank;
    logic [7:0]  index_ff, nxt_index, io_rdata_ff, nxt_io_rdata, cfg_rdata_ff, nxt_cfg_rdata;
    logic [3:0]  slot_ff, nxt_slot;
    hwm_pkg::hwm_tmode_t sys_mode_ff, cpu_mode_ff, nxt_sys_mode, nxt_cpu_mode;
    logic        io_dwr, wr_en, i2c_taken, pend_ff;
    logic [7:0]  wr_idx, wr_data, pend_idx_ff, pend_data_ff, i2c_idx_ff;

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        read_reg = 8'h00;
        if (idx == hwm_pkg::IDX_BANK) read_reg = {5'h00, bank_ff};
        else if (bank_ff == hwm_pkg::BANK_0) begin
            if (idx >= hwm_pkg::IDX_VOLT_BASE && idx <= hwm_pkg::IDX_VOLT_LAST)
                read_reg = volt_ff[3'(idx - hwm_pkg::IDX_VOLT_BASE)];
            else if (idx == hwm_pkg::IDX_SYS_TEMP) read_reg = sys_temp_ff;
            else if (idx == hwm_pkg::IDX_I2C_ADDR) read_reg = i2c_addr_ff;
            else if (idx == hwm_pkg::IDX_SEL_A) read_reg = sel_a_ff;
            else if (idx == hwm_pkg::IDX_SEL_B) read_reg = sel_b_ff;
            else if (idx == hwm_pkg::IDX_SEL_C) read_reg = sel_c_ff;
        end else if (bank_ff == hwm_pkg::BANK_1) begin
            if (idx == hwm_pkg::IDX_PAIR_HI) read_reg = cpu_temp_ff[8:1];
            else if (idx == hwm_pkg::IDX_PAIR_LO) read_reg = {cpu_temp_ff[0], 7'h00};
        end else if (bank_ff == hwm_pkg::BANK_5) begin
            if (idx == hwm_pkg::IDX_PAIR_HI) read_reg = volt_ff[hwm_pkg::SLOT_STBY[2:0]];
            else if (idx == hwm_pkg::IDX_PAIR_LO) read_reg = volt_ff[hwm_pkg::SLOT_BATT[2:0]];
        end
    endfunction

    function automatic hwm_pkg::hwm_tmode_t mode_of(input logic a, input logic b, input logic c);
        if (a) mode_of = hwm_pkg::TM_THERMISTOR;
        else if (b & c) mode_of = hwm_pkg::TM_DIODE_I;
        else mode_of = hwm_pkg::TM_DIODE_V;
    endfunction

    always_comb begin
        io_dwr    = io_req.cs & io_req.wr & io_req.port;
        i2c_taken = pend_ff & ~io_dwr;
        wr_en     = io_dwr | pend_ff;
        wr_idx    = io_dwr ? index_ff : pend_idx_ff;
        wr_data   = io_dwr ? io_req.wdata : pend_data_ff;
        nxt_index = (io_req.cs & io_req.wr & ~io_req.port) ? io_req.wdata : index_ff;
        nxt_io_rdata = io_rdata_ff;
        if (io_req.cs & io_req.rd) nxt_io_rdata = io_req.port ? read_reg(index_ff) : index_ff;
        nxt_bank     = bank_ff;
        nxt_i2c_addr = i2c_addr_ff;
        nxt_sel_a    = sel_a_ff;
        nxt_sel_b    = sel_b_ff;
        nxt_sel_c    = sel_c_ff;
        // Result registers have no write path
        if (wr_en) begin
            if (wr_idx == hwm_pkg::IDX_BANK) nxt_bank = wr_data[2:0];
            else if (bank_ff == hwm_pkg::BANK_0) begin
                if (wr_idx == hwm_pkg::IDX_I2C_ADDR) nxt_i2c_addr = wr_data;
                if (wr_idx == hwm_pkg::IDX_SEL_A) nxt_sel_a = wr_data;
                if (wr_idx == hwm_pkg::IDX_SEL_B) nxt_sel_b = wr_data;
                if (wr_idx == hwm_pkg::IDX_SEL_C) nxt_sel_c = wr_data;
            end
        end
        nxt_sys_mode  = mode_of(sel_a_ff[0], sel_b_ff[0], sel_c_ff[0]);
        nxt_cpu_mode  = mode_of(sel_a_ff[1], sel_b_ff[1], sel_c_ff[1]);
        nxt_sst_addr  = (cfg_wr && cfg_index == hwm_pkg::CFG_SST_ADDR) ? cfg_wdata : sst_addr_ff;
        nxt_cfg_rdata = (cfg_index == hwm_pkg::CFG_SST_ADDR) ? sst_addr_ff : 8'h00;
        nxt_volt     = volt_ff;
        nxt_sys_temp = sys_temp_ff;
        nxt_cpu_temp = cpu_temp_ff;
        nxt_slot     = slot_ff;
        if (adc.valid) begin
            if (slot_ff == hwm_pkg::SLOT_CPU) nxt_cpu_temp = adc.code;
            else if (slot_ff == hwm_pkg::SLOT_SYS) nxt_sys_temp = adc.code[7:0];
            else nxt_volt[slot_ff[2:0]] = adc.code[7:0];
            nxt_slot = (slot_ff == hwm_pkg::SLOT_CPU) ? 4'h0 : slot_ff + 4'h1;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) volt_ff[i] <= 8'h00;
            sys_temp_ff  <= 8'h00;
            cpu_temp_ff  <= 9'h000;
            i2c_addr_ff  <= hwm_pkg::RST_I2C_ADDR;
            sst_addr_ff  <= hwm_pkg::RST_SST_ADDR;
            sel_a_ff     <= hwm_pkg::RST_SEL;
            sel_b_ff     <= hwm_pkg::RST_SEL;
            sel_c_ff     <= hwm_pkg::RST_SEL;
            bank_ff      <= hwm_pkg::RST_BANK;
            index_ff     <= 8'h00;
            io_rdata_ff  <= 8'h00;
            cfg_rdata_ff <= 8'h00;
            slot_ff      <= 4'h0;
            sys_mode_ff  <= hwm_pkg::TM_THERMISTOR;
            cpu_mode_ff  <= hwm_pkg::TM_THERMISTOR;
        end else begin
            volt_ff      <= nxt_volt;
            sys_temp_ff  <= nxt_sys_temp;
            cpu_temp_ff  <= nxt_cpu_temp;
            i2c_addr_ff  <= nxt_i2c_addr;
            sst_addr_ff  <= nxt_sst_addr;
            sel_a_ff     <= nxt_sel_a;
            sel_b_ff     <= nxt_sel_b;
            sel_c_ff     <= nxt_sel_c;
            bank_ff      <= nxt_bank;
            index_ff     <= nxt_index;
            io_rdata_ff  <= nxt_io_rdata;
            cfg_rdata_ff <= nxt_cfg_rdata;
            slot_ff      <= nxt_slot;
            sys_mode_ff  <= nxt_sys_mode;
            cpu_mode_ff  <= nxt_cpu_mode;
        end
    end
    assign io_rdata  = io_rdata_ff;
    assign cfg_rdata = cfg_rdata_ff;
    assign adc_slot  = slot_ff;
    assign sys_mode  = sys_mode_ff;
    assign cpu_mode  = cpu_mode_ff;
    assign sst_address = sst_addr_ff;

    a_bank_select: assert property (io_dwr && index_ff == hwm_pkg::IDX_BANK
        |=> bank_ff == $past(io_req.wdata[2:0])) else $error("bank not selected");
    a_result_ro: assert property (io_dwr && index_ff == hwm_pkg::IDX_ASUP && !adc.valid
        |=> volt_ff[2] == $past(volt_ff[2])) else $error("result register written");
    a_sys_temp_rd: assert property (io_req.cs && io_req.rd && io_req.port
        && bank_ff == hwm_pkg::BANK_0 && index_ff == hwm_pkg::IDX_SYS_TEMP
        |=> io_rdata_ff == $past(sys_temp_ff)) else $error("bad system temp read");
    a_cpu_low_bit: assert property (io_req.cs && io_req.rd && io_req.port
        && bank_ff == hwm_pkg::BANK_1 && index_ff == hwm_pkg::IDX_PAIR_LO
        |=> io_rdata_ff == {$past(cpu_temp_ff[0]), 7'h00}) else $error("bad cpu low bit");
    a_slot_wrap: assert property (adc.valid && slot_ff == hwm_pkg::SLOT_CPU
        |=> slot_ff == 4'h0 && cpu_temp_ff == $past(adc.code)) else $error("bad slot wrap");
    a_sst_reset: assert property ($rose(rst_q_ff[1]) |-> sst_addr_ff == hwm_pkg::RST_SST_ADDR)
        else $error("bad single-wire address reset");

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave
    typedef enum logic [3:0] {I_IDLE, I_ADDR, I_AACK, I_INDEX, I_IACK, I_WDATA, I_WACK,
                              I_RDATA, I_RACK} hwm_i2c_st_t;
    hwm_i2c_st_t st_ff, nxt_st;
    logic [7:0]  shift_ff, nxt_shift, nxt_i2c_idx, nxt_pend_idx, nxt_pend_data;
    logic [3:0]  cnt_ff, nxt_cnt;
    logic        rw_ff, nxt_rw, oe_ff, nxt_oe, nxt_pend;
    always_comb begin
        nxt_st = st_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_rw = rw_ff;
        nxt_oe = oe_ff;
        nxt_i2c_idx = i2c_idx_ff;
        nxt_pend = pend_ff & ~i2c_taken;
        nxt_pend_idx = pend_idx_ff;
        nxt_pend_data = pend_data_ff;
        if (i2c_stop) begin
            nxt_st = I_IDLE;
            nxt_oe = 1'b0;
        end else if (i2c_start) begin
            nxt_st = I_ADDR;
            nxt_cnt = 4'h0;
            nxt_oe = 1'b0;
        end else if (scl_rise) begin
            if (st_ff == I_ADDR || st_ff == I_INDEX || st_ff == I_WDATA) begin
                nxt_shift = {shift_ff[6:0], sda_lvl_ff};
                nxt_cnt = cnt_ff + 4'h1;
            end else if (st_ff == I_RACK) begin
                if (sda_lvl_ff) nxt_st = I_IDLE;
                else nxt_i2c_idx = i2c_idx_ff + 8'h01;
            end
        end else if (scl_fall) begin
            unique case (st_ff)
                I_IDLE: ;
                I_ADDR: if (cnt_ff == 4'h8) begin
                    if (shift_ff[7:1] == i2c_addr_ff[6:0]) begin
                        nxt_rw = shift_ff[0];
                        nxt_oe = 1'b1;
                        nxt_st = I_AACK;
                    end else nxt_st = I_IDLE;
                end
                I_AACK, I_RACK: begin
                    nxt_cnt = 4'h0;
                    if (rw_ff) begin
                        nxt_shift = read_reg(nxt_i2c_idx);
                        nxt_oe = ~nxt_shift[7];
                        nxt_st = I_RDATA;
                    end else begin
                        nxt_oe = 1'b0;
                        nxt_st = I_INDEX;
                    end
                end
                I_INDEX: if (cnt_ff == 4'h8) begin
                    nxt_i2c_idx = shift_ff;
                    nxt_oe = 1'b1;
                    nxt_st = I_IACK;
                end
                I_IACK, I_WACK: begin
                    nxt_oe = 1'b0;
                    nxt_cnt = 4'h0;
                    nxt_st = I_WDATA;
                    if (st_ff == I_WACK) nxt_i2c_idx = i2c_idx_ff + 8'h01;
                end
                I_WDATA: if (cnt_ff == 4'h8) begin
                    nxt_pend = 1'b1;
                    nxt_pend_idx = i2c_idx_ff;
                    nxt_pend_data = shift_ff;
                    nxt_oe = 1'b1;
                    nxt_st = I_WACK;
                end
                I_RDATA: if (cnt_ff == 4'h7) begin
                    nxt_oe = 1'b0;
                    nxt_st = I_RACK;
                end else begin
                    nxt_shift = {shift_ff[6:0], 1'b1};
                    nxt_oe = ~shift_ff[6];
                    nxt_cnt = cnt_ff + 4'h1;
                end
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= I_IDLE;
            shift_ff <= 8'h00;
            cnt_ff <= 4'h0;
            rw_ff <= 1'b0;
            oe_ff <= 1'b0;
            i2c_idx_ff <= 8'h00;
            pend_ff <= 1'b0;
            pend_idx_ff <= 8'h00;
            pend_data_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            rw_ff <= nxt_rw;
            oe_ff <= nxt_oe;
            i2c_idx_ff <= nxt_i2c_idx;
            pend_ff <= nxt_pend;
            pend_idx_ff <= nxt_pend_idx;
            pend_data_ff <= nxt_pend_data;
        end
    end
    // Open drain: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = oe_ff;

    sequence s_addr_match;
        st_ff == I_ADDR && scl_fall && !i2c_stop && !i2c_start && cnt_ff == 4'h8
            && shift_ff[7:1] == i2c_addr_ff[6:0];
    endsequence
    a_i2c_addr_ack: assert property (s_addr_match |=> oe_ff && st_ff == I_AACK)
        else $error("no ack on own address");
    a_i2c_write: assert property (i2c_taken && bank_ff == hwm_pkg::BANK_0
        && pend_idx_ff == hwm_pkg::IDX_SEL_A |=> sel_a_ff == $past(pend_data_ff))
        else $error("serial write lost");

    ////////////////////////////////////////////////////////////////////////////
    // Single-wire bit-rate capture
    logic [15:0] idle_ff, nxt_idle, bit_cnt_ff, nxt_bit_cnt, bit_time_ff, nxt_bit_time;
    logic        meas_ff, nxt_meas;
    always_comb begin
        nxt_idle = nxt_sst_lvl ? 16'h0000 :
                   (idle_ff == hwm_pkg::SST_IDLE_CYC ? idle_ff : idle_ff + 16'h0001);
        nxt_meas = meas_ff;
        nxt_bit_cnt = (bit_cnt_ff == 16'hFFFF) ? bit_cnt_ff : bit_cnt_ff + 16'h0001;
        nxt_bit_time = bit_time_ff;
        if (sst_rise) begin
            if (meas_ff) begin
                nxt_bit_time = bit_cnt_ff;
                nxt_meas = 1'b0;
            end else if (idle_ff == hwm_pkg::SST_IDLE_CYC) begin
                nxt_meas = 1'b1;
                nxt_bit_cnt = 16'h0001;
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idle_ff <= 16'h0000;
            bit_cnt_ff <= 16'h0000;
            bit_time_ff <= 16'h0000;
            meas_ff <= 1'b0;
        end else begin
            idle_ff <= nxt_idle;
            bit_cnt_ff <= nxt_bit_cnt;
            bit_time_ff <= nxt_bit_time;
            meas_ff <= nxt_meas;
        end
    end
    assign sst_bit_time = bit_time_ff;

    a_sst_rate: assert property (meas_ff && sst_rise
        |=> !meas_ff && bit_time_ff == $past(bit_cnt_ff)) else $error("bit time not taken");
endmodule // hwm_readout
`default_nettype wire

// *** dv/hwm_adc_model.sv ***
// Converter model that feeds results into the monitor block
`default_nettype none
module hwm_adc_model (
    input  wire logic         go,    // Deliver one result now
    input  wire logic [8:0]   code,  // Result value
    output hwm_pkg::hwm_adc_t adc    // Result toward the block
);
    timeunit 1ns;
    timeprecision 1ns;
    // Code is inverted outside a result so a stale value never looks valid
    always_comb begin
        adc.valid = go;
        adc.code  = go ? code : ~code;
    end
endmodule // hwm_adc_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the monitor register block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clock = 1'b0;
    logic                 nrst = 1'b0;
    hwm_pkg::hwm_io_req_t io_req = '0;
    logic [7:0]           io_rdata, cfg_rdata, sst_address, sa, sb, sc;
    logic [7:0]           cfg_wdata = 8'h00;
    logic                 cfg_wr = 1'b0, sst_i = 1'b0, go = 1'b0, rd_seen = 1'b0;
    logic [7:0]           cfg_index = 8'hF1, sd;
    logic                 scl = 1'b1, drv = 1'b1, sda, sda_oe;
    logic [2:0]           acks;
    logic [15:0]          rd2;
    logic [8:0]           code = 9'h000;
    logic [3:0]           adc_slot;
    logic [15:0]          sst_bit_time;
    hwm_pkg::hwm_adc_t    adc;
    hwm_pkg::hwm_tmode_t  sys_mode, cpu_mode;
    logic [8:0]           codes [10];
    logic [7:0]           exp_q [$];
    int                   fails = 0, num_checks = 0, n;

    always #50 clock = ~clock;

    // Pulled-up data line: low while either end pulls it
    assign sda = drv & ~sda_oe;

    hwm_adc_model i_adc (.go(go), .code(code), .adc(adc));
    hwm_readout i_dut (
        .clock(clock), .nrst(nrst), .io_req(io_req), .io_rdata(io_rdata),
        .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .adc(adc), .adc_slot(adc_slot), .sys_mode(sys_mode),
        .cpu_mode(cpu_mode), .sst_i(sst_i), .sst_address(sst_address),
        .sst_bit_time(sst_bit_time)
    );

    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic io(logic p, logic w, logic r, logic [7:0] d);
        io_req = '{cs: 1'b1, port: p, wr: w, rd: r, wdata: d};
        @(negedge clock);
    endtask
    task automatic wr_reg(logic [7:0] i, logic [7:0] d);
        io(1'b0, 1'b1, 1'b0, i);
        io(1'b1, 1'b1, 1'b0, d);
    endtask
    task automatic rd_reg(logic [7:0] i, logic [7:0] e);
        io(1'b0, 1'b1, 1'b0, i);
        exp_q.push_back(e);
        io(1'b1, 1'b0, 1'b1, 8'h00);
    endtask
    function automatic logic [1:0] mode(int b);
        return sa[b] ? 2'h0 : ((sb[b] & sc[b]) ? 2'h2 : 2'h1);
    endfunction
    task automatic stop_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Serial master: data bits move only while the clock is low
    task automatic wait_n(int q);
        repeat (q) @(negedge clock);
    endtask
    task automatic put_bit(logic b, output logic got);
        drv = b;
        wait_n(5);
        scl = 1'b1;
        wait_n(3);
        got = sda;
        wait_n(3);
        scl = 1'b0;
        wait_n(2);
    endtask
    task automatic i2c_start();
        drv = 1'b1;
        wait_n(5);
        scl = 1'b1;
        wait_n(5);
        drv = 1'b0;
        wait_n(5);
        scl = 1'b0;
        wait_n(2);
    endtask
    task automatic i2c_stop();
        drv = 1'b0;
        wait_n(5);
        scl = 1'b1;
        wait_n(5);
        drv = 1'b1;
        wait_n(5);
    endtask
    task automatic send(logic [7:0] b, output logic ack);
        logic got;
        for (int i = 7; i >= 0; i--) put_bit(b[i], got);
        put_bit(1'b1, got);
        ack = ~got;
    endtask
    task automatic recv(logic last, output logic [7:0] b);
        logic got;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
        put_bit(last, got);
    endtask

    // Read data lands one cycle after the read strobe
    always @(posedge clock) begin
        if (rd_seen) chk("io_rdata", exp_q.pop_front(), io_rdata);
        rd_seen <= io_req.cs & io_req.rd;
    end

    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        stop_test();
    end

    initial begin
        n = $urandom(32'h50585303);
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        chk("sst_address", 16'h0048, sst_address);
        for (int i = 0; i < 10; i++) begin
            codes[i] = 9'($urandom);
            code = codes[i];
            go = 1'b1;
            @(negedge clock);
            go = 1'b0;
            @(negedge clock);
            chk("adc_slot", 16'((i + 1) % 10), adc_slot);
        end
        for (int i = 0; i < 6; i++) rd_reg(8'h20 + 8'(i), codes[i][7:0]);
        rd_reg(8'h27, codes[8][7:0]);
        wr_reg(8'h22, ~codes[2][7:0]);
        rd_reg(8'h22, codes[2][7:0]);
        rd_reg(8'h30, 8'h00);
        wr_reg(8'h4E, 8'h01);
        rd_reg(8'h50, codes[9][8:1]);
        rd_reg(8'h51, {codes[9][0], 7'h00});
        wr_reg(8'h4E, 8'h05);
        rd_reg(8'h4E, 8'h05);
        rd_reg(8'h50, codes[6][7:0]);
        rd_reg(8'h51, codes[7][7:0]);
        wr_reg(8'h4E, 8'h00);
        for (int k = 0; k < 6; k++) begin
            sa = 8'($urandom);
            sb = 8'($urandom);
            sc = 8'($urandom);
            wr_reg(8'h59, sa);
            wr_reg(8'h5D, sb);
            wr_reg(8'h5E, sc);
            wr_reg(8'h48, sb);
            rd_reg(8'h48, sb);
            io_req = '0;
            repeat (2) @(negedge clock);
            chk("sys_mode", 16'(mode(0)), 16'(sys_mode));
            chk("cpu_mode", 16'(mode(1)), 16'(cpu_mode));
        end
        // Serial write to 59h, read back with auto-increment, then a foreign address
        sd = 8'($urandom);
        i2c_start();
        send({sb[6:0], 1'b0}, acks[2]);
        send(8'h59, acks[1]);
        send(sd, acks[0]);
        i2c_stop();
        chk("i2c_wr_ack", 16'h0007, 16'(acks));
        i2c_start();
        send({sb[6:0], 1'b0}, acks[2]);
        send(8'h59, acks[1]);
        i2c_start();
        send({sb[6:0], 1'b1}, acks[0]);
        recv(1'b0, rd2[15:8]);
        recv(1'b1, rd2[7:0]);
        i2c_stop();
        chk("i2c_rd_ack", 16'h0007, 16'(acks));
        chk("i2c_rdata", {sd, 8'h00}, rd2);
        i2c_start();
        send({~sb[6:0], 1'b0}, acks[2]);
        send(8'h59, acks[1]);
        send(~sd, acks[0]);
        i2c_stop();
        chk("i2c_nack", 16'h0000, 16'(acks));
        rd_reg(8'h59, sd);
        io_req = '0;
        cfg_wdata = 8'($urandom);
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
        repeat (2) @(negedge clock);
        chk("sst_address", 16'(cfg_wdata), sst_address);
        chk("cfg_rdata", 16'(cfg_wdata), cfg_rdata);
        cfg_index = 8'h30;
        repeat (2) @(negedge clock);
        chk("cfg_rdata", 16'h0000, cfg_rdata);
        repeat (60) @(negedge clock);
        n = 20 + ($urandom % 40);
        sst_i = 1'b1;
        repeat (4) @(negedge clock);
        sst_i = 1'b0;
        repeat (n - 4) @(negedge clock);
        sst_i = 1'b1;
        repeat (8) @(negedge clock);
        chk("sst_bit_time", 16'(n), sst_bit_time);
        stop_test();
    end
endmodule // tb
`default_nettype wire
